// *** rtl/api_tx_parser.sv ***
// Notes on behaviour
// - In escaped mode, 0x7D 0x33 on the line is restored to 0x13.
// - Checksum equals 0xFF minus low byte of sum from type through payload.
// - Type 0x10 has options at 16, payload from 17; 0x11 adds fields.
// - Destination 0x000000000000FFFF means broadcast, not unicast.
// - Frame identifier at offset 4 is echoed in status; zero means none.
// - Destination address spans offsets 5 to 12, most significant byte first.
// - Explicit frame radius at 21; zero takes the configured maximum hops.
// - Radius above maximum hops is clamped; unicast ignores the radius.
// - Explicit frame source endpoint at 15, destination endpoint at 16.
// - Explicit frame cluster identifier at 17 to 18, high byte first.
// - Explicit frame profile identifier at 19 to 20, high byte first.
// - Explicit frame options at 22, payload from 23 to before checksum.
// - Option bit 0 suppresses acknowledgments for unicasts.
// - Option bit 1 suppresses route discovery for mesh unicasts.
// - Option bit 2 enables negative acknowledgments for mesh packets.
// - Option bit 3 requests a route trace for mesh packets.
// - Option bits 7:6 pick delivery: 01 multipoint, 10 directed, 11 mesh, 00 invalid.
//
// The implementer's own choices: the register offsets and the APB slave port.
module api_tx_parser
    import api_tx_pkg::*;
#(
    parameter logic [7:0] MAX_HOP_RST_P = MAX_HOP_RST,
    parameter logic [15:0] MAX_PAYLOAD = MAX_PAY_RST
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bytes from the serial receiver
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    // Payload stream
    output logic [7:0] pay_byte,
    output logic pay_valid,
    // Frame outcome
    output logic frame_good,
    output logic frame_bad,
    output logic status_req,
    output logic [7:0] status_id
);

    parse_state_t state_r;
    logic framing_escape_mode;
    logic [7:0] max_hop_setting;
    logic [7:0] u_byte;
    logic u_valid;
    logic u_delim;
    logic [15:0] len_r;
    logic [15:0] remain_r;
    logic [15:0] pos_r;
    logic [7:0] sum_r;
    logic err_r;
    logic [7:0] w_type_r, w_id_r, w_src_r, w_dst_r, w_radius_r, w_opts_r;
    logic [63:0] w_addr_r;
    logic [15:0] w_cluster_r, w_profile_r, w_paylen_r;
    logic [7:0] c_type_r, c_id_r, c_src_r, c_dst_r, c_radius_r, c_opts_r;
    logic [63:0] c_addr_r;
    logic [15:0] c_cluster_r, c_profile_r, c_paylen_r;
    logic c_bcast_r, c_no_ack_r, c_no_route_r, c_nack_r, c_trace_r;
    logic [7:0] good_cnt_r, bad_cnt_r;
    logic is_expl, is_pay, csum_ok, len_ok, w_bcast, commit, restart;
    logic [7:0] eff_radius;
    logic [31:0] rd_mux;
    logic rd_err;

    // Byte restoration ahead of the parser
    api_unescape u_unesc (
        .pclk(pclk),
        .presetn(presetn),
        .escape_en(framing_escape_mode),
        .in_byte(rx_byte),
        .in_valid(rx_valid),
        .out_byte(u_byte),
        .out_valid(u_valid),
        .out_delim(u_delim)
    );

    // Frame-level decode terms
    assign is_expl = (w_type_r == TYPE_EXPL);
    assign is_pay = is_expl ? (pos_r >= OFS_EX_PAY) : (pos_r >= OFS_TX_PAY);
    assign csum_ok = (8'(sum_r + u_byte) == CSUM_GOOD);
    assign len_ok = len_r >= (is_expl ? LEN_MIN_EX : LEN_MIN_TX);
    assign w_bcast = (w_addr_r == BCAST_ADDR);
    assign commit = (state_r == ST_CSUM) && u_valid && !restart; // Raw 0x7e is a plain checksum only with escaped mode off
    // Only escaped mode makes a mid-frame delimiter unambiguous
    assign restart = framing_escape_mode && u_valid && u_delim && (state_r != ST_IDLE);

    // Radius: zero or too large takes the hop setting; unicast reports zero
    always_comb begin
        if (!w_bcast) begin
            eff_radius = 8'h00;
        end else if (w_radius_r == 8'h00 || w_radius_r > max_hop_setting) begin
            eff_radius = max_hop_setting;
        end else begin
            eff_radius = w_radius_r;
        end
    end

    // Framing state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            len_r <= 16'h0000;
            remain_r <= 16'h0000;
            pos_r <= 16'h0000;
            sum_r <= 8'h00;
        end else if (u_valid && u_delim && (state_r == ST_IDLE || restart)) begin
            state_r <= ST_LEN_HI;
        end else if (u_valid) begin
            case (state_r)
                ST_IDLE: state_r <= ST_IDLE;
                ST_LEN_HI: begin
                    len_r <= {u_byte, 8'h00};
                    state_r <= ST_LEN_LO;
                end
                ST_LEN_LO: begin
                    len_r <= {len_r[15:8], u_byte};
                    remain_r <= {len_r[15:8], u_byte};
                    pos_r <= OFS_TYPE;
                    sum_r <= 8'h00;
                    state_r <= ({len_r[15:8], u_byte} == 16'h0000) ? ST_IDLE : ST_BODY;
                end
                ST_BODY: begin
                    sum_r <= 8'(sum_r + u_byte);
                    pos_r <= 16'(pos_r + 16'h0001);
                    remain_r <= 16'(remain_r - 16'h0001);
                    if (remain_r == 16'h0001) begin
                        state_r <= ST_CSUM;
                    end
                end
                ST_CSUM: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Field capture by offset while the body streams in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_type_r <= 8'h00;
            w_id_r <= 8'h00;
            w_addr_r <= 64'h0;
            w_src_r <= 8'h00;
            w_dst_r <= 8'h00;
            w_cluster_r <= 16'h0000;
            w_profile_r <= 16'h0000;
            w_radius_r <= 8'h00;
            w_opts_r <= 8'h00;
            w_paylen_r <= 16'h0000;
            err_r <= 1'b0;
        end else if (u_valid && state_r == ST_LEN_LO) begin
            w_src_r <= 8'h00;
            w_dst_r <= 8'h00;
            w_cluster_r <= 16'h0000;
            w_profile_r <= 16'h0000;
            w_paylen_r <= 16'h0000;
            err_r <= 1'b0;
        end else if (u_valid && state_r == ST_BODY) begin
            if (pos_r == OFS_TYPE) begin
                w_type_r <= u_byte;
                err_r <= (u_byte != TYPE_TX) && (u_byte != TYPE_EXPL);
            end else if (pos_r == OFS_ID) begin
                w_id_r <= u_byte;
            end else if (pos_r >= OFS_ADDR_FIRST && pos_r <= OFS_ADDR_LAST) begin
                w_addr_r <= {w_addr_r[55:0], u_byte};
            end else if (is_pay) begin
                w_paylen_r <= 16'(w_paylen_r + 16'h0001);
                if (w_paylen_r >= MAX_PAYLOAD) begin
                    err_r <= 1'b1;
                end
            end else if (!is_expl) begin
                if (pos_r == OFS_TX_RADIUS) begin
                    w_radius_r <= u_byte;
                end
                if (pos_r == OFS_TX_OPTS) begin
                    w_opts_r <= u_byte;
                end
            end else begin
                if (pos_r == OFS_SRC_EP) begin
                    w_src_r <= u_byte;
                end
                if (pos_r == OFS_DST_EP) begin
                    w_dst_r <= u_byte;
                end
                if (pos_r == OFS_CLUSTER_HI || pos_r == OFS_CLUSTER_LO) begin
                    w_cluster_r <= {w_cluster_r[7:0], u_byte};
                end
                if (pos_r == OFS_PROFILE_HI || pos_r == OFS_PROFILE_LO) begin
                    w_profile_r <= {w_profile_r[7:0], u_byte};
                end
                if (pos_r == OFS_EX_RADIUS) begin
                    w_radius_r <= u_byte;
                end
                if (pos_r == OFS_EX_OPTS) begin
                    w_opts_r <= u_byte;
                end
            end
        end
    end

    // Payload leaves before the checksum; consumers drop it on frame_bad
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pay_byte <= 8'h00;
            pay_valid <= 1'b0;
        end else begin
            pay_valid <= u_valid && state_r == ST_BODY && is_pay && !err_r;
            if (u_valid) begin
                pay_byte <= u_byte;
            end
        end
    end

    // Commit a checked frame; any other frame of nonzero length is discarded and counted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_good <= 1'b0;
            frame_bad <= 1'b0;
            status_req <= 1'b0;
            status_id <= 8'h00;
            good_cnt_r <= 8'h00;
            bad_cnt_r <= 8'h00;
            c_type_r <= 8'h00;
            c_id_r <= 8'h00;
            c_addr_r <= 64'h0;
            c_src_r <= 8'h00;
            c_dst_r <= 8'h00;
            c_cluster_r <= 16'h0000;
            c_profile_r <= 16'h0000;
            c_radius_r <= 8'h00;
            c_opts_r <= 8'h00;
            c_paylen_r <= 16'h0000;
            c_bcast_r <= 1'b0;
            c_no_ack_r <= 1'b0;
            c_no_route_r <= 1'b0;
            c_nack_r <= 1'b0;
            c_trace_r <= 1'b0;
        end else begin
            frame_good <= commit && csum_ok && !err_r && len_ok;
            frame_bad <= restart || (commit && !(csum_ok && !err_r && len_ok));
            status_req <= commit && csum_ok && !err_r && len_ok && w_id_r != 8'h00;
            if (commit && csum_ok && !err_r && len_ok) begin
                good_cnt_r <= 8'(good_cnt_r + 8'h01);
                status_id <= w_id_r;
                c_type_r <= w_type_r;
                c_id_r <= w_id_r;
                c_addr_r <= w_addr_r;
                c_src_r <= w_src_r;
                c_dst_r <= w_dst_r;
                c_cluster_r <= w_cluster_r;
                c_profile_r <= w_profile_r;
                c_radius_r <= eff_radius;
                c_opts_r <= w_opts_r;
                c_paylen_r <= w_paylen_r;
                c_bcast_r <= w_bcast;
                c_no_ack_r <= w_opts_r[OPT_NO_ACK] && !w_bcast;
                c_no_route_r <= w_opts_r[OPT_NO_ROUTE] && !w_bcast && w_opts_r[7:6] == METH_MESH;
                c_nack_r <= w_opts_r[OPT_NACK] && w_opts_r[7:6] == METH_MESH;
                c_trace_r <= w_opts_r[OPT_TRACE] && w_opts_r[7:6] == METH_MESH;
            end else if (restart || commit) begin
                bad_cnt_r <= 8'(bad_cnt_r + 8'h01);
            end
        end
    end

    // Read multiplexer; unmapped addresses answer with an error
    always_comb begin
        rd_err = 1'b0;
        case (paddr)
            REG_CTRL: rd_mux = {MAX_PAYLOAD, max_hop_setting, 7'h00, framing_escape_mode};
            REG_STATUS: rd_mux = {bad_cnt_r, good_cnt_r, 6'h00, c_opts_r[7:6],
                c_trace_r, c_nack_r, c_no_route_r, c_no_ack_r,
                c_opts_r[7:6] == METH_INVALID, is_expl, c_bcast_r, (state_r != ST_IDLE)};
            REG_ADDR_HI: rd_mux = c_addr_r[63:32];
            REG_ADDR_LO: rd_mux = c_addr_r[31:0];
            REG_IDENT: rd_mux = {c_dst_r, c_src_r, c_type_r, c_id_r};
            REG_APP: rd_mux = {c_cluster_r, c_profile_r};
            REG_XMIT: rd_mux = {c_paylen_r, c_opts_r, c_radius_r};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_err = 1'b1;
            end
        endcase
    end

    // APB: one wait state, so read data and error are registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= rd_err;
            end
        end
    end

    // Control register written at the completing edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            framing_escape_mode <= 1'b0;
            max_hop_setting <= MAX_HOP_RST_P;
        end else if (psel && penable && pready && pwrite && paddr == REG_CTRL) begin
            framing_escape_mode <= pwdata[CTRL_ESC_BIT];
            max_hop_setting <= pwdata[CTRL_HOP_LSB +: 8];
        end
    end

    a_csum_good:
    assert property (@(posedge pclk) disable iff (!presetn)
        frame_good |-> $past(state_r == ST_CSUM && 8'(sum_r + u_byte) == CSUM_GOOD))
    else $error("frame accepted with wrong checksum");

    a_bad_dropped:
    assert property (@(posedge pclk) disable iff (!presetn)
        (commit && !csum_ok) |=> (frame_bad && !frame_good && !status_req && $stable(c_addr_r)))
    else $error("failed frame was not discarded");

    a_bcast_detect:
    assert property (@(posedge pclk) disable iff (!presetn)
        frame_good |-> (c_bcast_r == (c_addr_r == BCAST_ADDR)))
    else $error("broadcast flag disagrees with address");

    a_radius_zero:
    assert property (@(posedge pclk) disable iff (!presetn)
        (frame_good && c_bcast_r && $past(w_radius_r) == 8'h00) |-> c_radius_r == $past(max_hop_setting))
    else $error("zero radius not replaced by hop setting");

    a_radius_clamp:
    assert property (@(posedge pclk) disable iff (!presetn)
        frame_good |-> (c_bcast_r ? c_radius_r <= $past(max_hop_setting) : c_radius_r == 8'h00))
    else $error("radius not clamped or not ignored");

    a_status_echo:
    assert property (@(posedge pclk) disable iff (!presetn)
        status_req |-> (frame_good && status_id != 8'h00 && status_id == c_id_r))
    else $error("status request without echoed identifier");

    a_pay_offset:
    assert property (@(posedge pclk) disable iff (!presetn)
        pay_valid |-> $past(pos_r) >= ($past(w_type_r) == TYPE_EXPL ? OFS_EX_PAY : OFS_TX_PAY))
    else $error("payload emitted from a header offset");

    a_no_ack_uni:
    assert property (@(posedge pclk) disable iff (!presetn)
        frame_good |-> (c_no_ack_r == (c_opts_r[OPT_NO_ACK] && !c_bcast_r)))
    else $error("acknowledge suppression decoded wrong");

    a_trace_mesh:
    assert property (@(posedge pclk) disable iff (!presetn)
        frame_good |-> (c_trace_r == (c_opts_r[OPT_TRACE] && c_opts_r[7:6] == METH_MESH)))
    else $error("route trace decoded wrong");

endmodule

// *** rtl/api_tx_pkg.sv ***
package api_tx_pkg;

    // Framing bytes
    localparam logic [7:0] START_DELIM = 8'h7e;
    localparam logic [7:0] ESC_BYTE = 8'h7d;
    localparam logic [7:0] ESC_XOR = 8'h20;
    localparam logic [7:0] CSUM_GOOD = 8'hff;

    // Frame types accepted, and the status frame that echoes the identifier
    localparam logic [7:0] TYPE_TX = 8'h10;
    localparam logic [7:0] TYPE_EXPL = 8'h11;
    localparam logic [7:0] TYPE_TX_STATUS = 8'h8b;

    localparam logic [63:0] BCAST_ADDR = 64'h0000_0000_0000_ffff;

    // Byte offsets inside a frame, counted from the start delimiter
    localparam logic [15:0] OFS_TYPE = 16'h0003;
    localparam logic [15:0] OFS_ID = 16'h0004;
    localparam logic [15:0] OFS_ADDR_FIRST = 16'h0005;
    localparam logic [15:0] OFS_ADDR_LAST = 16'h000c;
    localparam logic [15:0] OFS_TX_RADIUS = 16'h000f;
    localparam logic [15:0] OFS_TX_OPTS = 16'h0010;
    localparam logic [15:0] OFS_TX_PAY = 16'h0011;
    localparam logic [15:0] OFS_SRC_EP = 16'h000f;
    localparam logic [15:0] OFS_DST_EP = 16'h0010;
    localparam logic [15:0] OFS_CLUSTER_HI = 16'h0011;
    localparam logic [15:0] OFS_CLUSTER_LO = 16'h0012;
    localparam logic [15:0] OFS_PROFILE_HI = 16'h0013;
    localparam logic [15:0] OFS_PROFILE_LO = 16'h0014;
    localparam logic [15:0] OFS_EX_RADIUS = 16'h0015;
    localparam logic [15:0] OFS_EX_OPTS = 16'h0016;
    localparam logic [15:0] OFS_EX_PAY = 16'h0017;

    // Least length field that still holds every header byte
    localparam logic [15:0] LEN_MIN_TX = 16'h000e;
    localparam logic [15:0] LEN_MIN_EX = 16'h0014;

    // Option byte fields
    localparam int OPT_NO_ACK = 0;
    localparam int OPT_NO_ROUTE = 1;
    localparam int OPT_NACK = 2;
    localparam int OPT_TRACE = 3;
    localparam logic [1:0] METH_INVALID = 2'h0;
    localparam logic [1:0] METH_P2MP = 2'h1;
    localparam logic [1:0] METH_DIRECTED = 2'h2;
    localparam logic [1:0] METH_MESH = 2'h3;

    // Register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ADDR_HI = 8'h08;
    localparam logic [7:0] REG_ADDR_LO = 8'h0c;
    localparam logic [7:0] REG_IDENT = 8'h10;
    localparam logic [7:0] REG_APP = 8'h14;
    localparam logic [7:0] REG_XMIT = 8'h18;

    // Control field positions and reset values
    localparam int CTRL_ESC_BIT = 0;
    localparam int CTRL_HOP_LSB = 8;
    localparam logic [7:0] MAX_HOP_RST = 8'h07;
    localparam logic [15:0] MAX_PAY_RST = 16'h0100;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_LEN_HI = 5'b00010,
        ST_LEN_LO = 5'b00100,
        ST_BODY = 5'b01000,
        ST_CSUM = 5'b10000
    } parse_state_t;

endpackage

// *** rtl/api_unescape.sv ***
module api_unescape
    import api_tx_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Mode and raw serial bytes
    input wire logic escape_en,
    input wire logic [7:0] in_byte,
    input wire logic in_valid,
    // Restored bytes
    output logic [7:0] out_byte,
    output logic out_valid,
    output logic out_delim
);

    logic pend_r;

    // Escape marker is swallowed; the next byte is restored by xor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= 1'b0;
            out_byte <= 8'h00;
            out_valid <= 1'b0;
            out_delim <= 1'b0;
        end else if (in_valid) begin
            if (escape_en && !pend_r && in_byte == ESC_BYTE) begin
                pend_r <= 1'b1;
                out_valid <= 1'b0;
                out_delim <= 1'b0;
            end else begin
                pend_r <= 1'b0;
                out_valid <= 1'b1;
                out_byte <= pend_r ? (in_byte ^ ESC_XOR) : in_byte;
                out_delim <= !pend_r && in_byte == START_DELIM;
            end
        end else begin
            out_valid <= 1'b0;
            out_delim <= 1'b0;
            if (!escape_en) begin
                pend_r <= 1'b0;
            end
        end
    end

    a_esc_restore:
    assert property (@(posedge pclk) disable iff (!presetn)
        (in_valid && pend_r) |=> (out_valid && out_byte == ($past(in_byte) ^ ESC_XOR) && !out_delim))
    else $error("escaped byte not restored");

    a_esc_pair_13:
    assert property (@(posedge pclk) disable iff (!presetn)
        (escape_en && in_valid && !pend_r && in_byte == ESC_BYTE) ##1 (in_valid && in_byte == 8'h33)
        |=> (out_valid && out_byte == 8'h13))
    else $error("escape pair 7d 33 not turned into 13");

endmodule

// *** verification/host_frame_src.sv ***
module host_frame_src (
    // Clock
    input wire logic pclk,
    // Serial bytes toward the device
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    bit slow = 1'b0;

    initial begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
    end

    // Idle gaps show a changed byte so stale data never looks valid
    task automatic put(input logic [7:0] b);
        rx_byte <= b;
        rx_valid <= 1'b1;
        @(posedge pclk);
        if (slow) begin
            rx_valid <= 1'b0;
            rx_byte <= ~b;
            @(posedge pclk);
        end
    endtask

    // Delimiter is never escaped, so in escaped mode it always resyncs the receiver
    task automatic emit(input logic [7:0] b, input bit esc, input bit raw);
        if (esc && !raw && (b == 8'h7e || b == 8'h7d || b == 8'h11 || b == 8'h13)) begin
            put(8'h7d);
            put(b ^ 8'h20);
        end else begin
            put(b);
        end
    endtask

    // Whole frame: delimiter, length, body, checksum
    task automatic send(input logic [7:0] body[$], input bit esc, input logic [7:0] flip);
        logic [7:0] sum;
        sum = 8'h00;
        foreach (body[i]) sum += body[i];
        emit(8'h7e, esc, 1'b1);
        emit(8'(body.size() >> 8), esc, 1'b0);
        emit(8'(body.size()), esc, 1'b0);
        foreach (body[i]) emit(body[i], esc, 1'b0);
        emit((8'hff - sum) ^ flip, esc, 1'b0);
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
    endtask
endmodule

// *** verification/tb.sv ***
module tb;
    import api_tx_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_valid, pay_valid, frame_good, frame_bad, status_req;
    logic [7:0] paddr, rx_byte, pay_byte, status_id, last_id, hop;
    logic [31:0] pwdata, prdata, q;
    logic e;
    bit esc;
    int mismatches, total_checks, cycles, good_n, bad_n, st_n, exp_good, exp_bad, exp_st;
    logic [7:0] got[$];
    logic [7:0] mth[4] = '{8'h40, 8'h80, 8'hc0, 8'h00};
    logic [7:0] rads[4] = '{8'h04, 8'h00, 8'h00, 8'h09};

    api_tx_parser dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .pay_byte(pay_byte), .pay_valid(pay_valid), .frame_good(frame_good),
        .frame_bad(frame_bad), .status_req(status_req), .status_id(status_id));
    host_frame_src host (.pclk(pclk), .rx_byte(rx_byte), .rx_valid(rx_valid));

    // Clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Collect outputs; cycle limit cuts a hang short
    always @(posedge pclk) begin
        cycles++;
        if (pay_valid === 1'b1) got.push_back(pay_byte);
        if (frame_good === 1'b1) good_n++;
        if (frame_bad === 1'b1) bad_n++;
        if (status_req === 1'b1) st_n++;
        if (status_req === 1'b1) last_id = status_id;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Held until pready is sampled high; no latency assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic run(input logic [7:0] ty, id, input logic [63:0] ad, input logic [7:0] rad, op, input int np,
        input logic [7:0] flip);
        logic [7:0] b[$];
        logic [7:0] pay[$];
        logic uni, mesh, x;
        b = {ty, id};
        for (int i = 7; i >= 0; i--) b.push_back(ad[i*8 +: 8]);
        b = {b, 8'hff, 8'hfe};
        if (ty == TYPE_EXPL) b = {b, 8'he8, 8'h3c, 8'h00, 8'h11, 8'hc1, 8'h05};
        for (int i = 0; i < np; i++) pay.push_back(8'($urandom));
        b = {b, rad, op, pay};
        got.delete();
        host.send(b, esc, flip);
        repeat (3) @(posedge pclk);
        uni = ad != BCAST_ADDR;
        mesh = op[7:6] == 2'b11;
        x = ty == TYPE_EXPL;
        if (flip != 8'h00) begin
            exp_bad++;
            check("bad count", bad_n, exp_bad);
            check("good count", good_n, exp_good);
        end else begin
            exp_good++;
            check("good count", good_n, exp_good);
            if (id != 0) exp_st++;
            check("status count", st_n, exp_st);
            if (id != 0) check("status id", last_id, id);
            check("payload size", got.size(), np);
            foreach (pay[i]) check("payload", got[i], pay[i]);
            apb(1'b0, REG_ADDR_HI, 32'h0);
            check("addr hi", q, ad[63:32]);
            apb(1'b0, REG_ADDR_LO, 32'h0);
            check("addr lo", q, ad[31:0]);
            apb(1'b0, REG_IDENT, 32'h0);
            check("ident", q, {x ? 16'h3ce8 : 16'h0, ty, id});
            apb(1'b0, REG_APP, 32'h0);
            check("cluster profile", q, x ? 32'h0011_c105 : 32'h0);
            apb(1'b0, REG_XMIT, 32'h0);
            check("xmit", q, {16'(np), op, uni ? 8'h0 : (rad == 0 || rad > hop) ? hop : rad});
            apb(1'b0, REG_STATUS, 32'h0);
            check("status", q & 32'hffff03ff, {8'(exp_bad), 8'(exp_good), 6'h0, op[7:6], op[3] & mesh, op[2] & mesh,
                op[1] & uni & mesh, op[0] & uni, op[7:6] == 2'b00, x, !uni, 1'b0});
        end
        $display("frame type %h done", ty);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        hop = MAX_HOP_RST;
        void'($urandom(32'h6f1f));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, REG_CTRL, 32'h0);
        check("ctrl reset", q, {MAX_PAY_RST, MAX_HOP_RST, 8'h00});
        apb(1'b0, 8'h1c, 32'h0);
        check("unmapped err", e, 1'b1);
        for (int k = 0; k < 4; k++) run(k[0] ? TYPE_EXPL : TYPE_TX, 8'(k + 1), k[1] ? BCAST_ADDR : {$urandom, $urandom},
            rads[k], mth[k] | 8'($urandom & 15), 3 + k, 8'h00);
        apb(1'b1, REG_CTRL, 32'h0000_0501);
        esc = 1'b1;
        hop = 8'h05;
        // Back to back first, so the escape pair lands in adjacent cycles
        run(TYPE_TX, 8'h00, 64'h0013_7e7d_1100_00a2, 8'h00, 8'hc1, 4, 8'h00);
        host.slow = 1'b1;
        run(TYPE_EXPL, 8'h13, BCAST_ADDR, 8'h06, 8'hcf, 2, 8'h00);
        // Raw delimiter cuts a frame short; the cut frame counts as bad
        host.put(8'h7e);
        host.put(8'h00);
        host.put(8'h05);
        host.put(8'h10);
        exp_bad++;
        run(TYPE_EXPL, 8'h7e, BCAST_ADDR, 8'h03, 8'h40, 2, 8'h00);
        run(TYPE_TX, 8'h09, BCAST_ADDR, 8'h00, 8'h40, 2, 8'h01);
        complete_run();
    end
endmodule
